// >>> verif/test_camera_event_irq_mask.sv
`timescale 1ns/1ns
`default_nettype none
module test_camera_event_irq_mask;
    import ceim_pkg::*;
    logic        clk            = 1'b0;
    logic        rst            = 1'b1;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] event_pulse    = 32'h0000_0000;
    logic        irq;
    logic [31:0] rdat;
    int          fails          = 0;
    int          num_checks     = 0;

    always #20 clk = ~clk;

    ceim_irq_mask u_ceim_irq_mask (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_pulse(event_pulse), .irq(irq)
    );

    // Hold request until waitrequest is seen low, then release
    task access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : access

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        access(1'b0, CEIM_OFS_ENABLE, 32'h0);
        chk(rdat, CEIM_RST_ENABLE);
        access(1'b0, CEIM_OFS_STATUS, 32'h0);
        chk(rdat, CEIM_RST_STATUS);
        access(1'b1, CEIM_OFS_ENABLE, 32'hFFFF_FFFF);
        access(1'b0, CEIM_OFS_ENABLE, 32'h0);
        chk(rdat, CEIM_EVT_MASK);
        access(1'b0, 8'h20, 32'h0);
        chk(rdat, CEIM_RDATA_UNMAPPED);
        for (int i = 0; i < 32; i++) begin
            if (CEIM_EVT_MASK[i]) begin
                access(1'b1, CEIM_OFS_ENABLE, ~(32'h1 << i));
                event_pulse <= 32'h1 << i;
                @(posedge clk);
                event_pulse <= 32'h0;
                @(posedge clk);
                access(1'b0, CEIM_OFS_STATUS, 32'h0);
                chk(rdat, 32'h1 << i);
                chk({31'h0, irq}, 32'h0);
                access(1'b1, CEIM_OFS_ENABLE, 32'h1 << i);
                chk({31'h0, irq}, 32'h1);
                access(1'b1, CEIM_OFS_STATUS, ~(32'h1 << i));
                chk({31'h0, irq}, 32'h1);
                access(1'b1, CEIM_OFS_STATUS, 32'h1 << i);
                chk({31'h0, irq}, 32'h0);
            end
        end
        access(1'b1, CEIM_OFS_ENABLE, 32'h0);
        avs_byteenable <= 4'h4;
        access(1'b1, CEIM_OFS_ENABLE, 32'hFFFF_FFFF);
        avs_byteenable <= 4'hB;
        access(1'b1, CEIM_OFS_ENABLE, 32'h0);
        avs_byteenable <= 4'hF;
        access(1'b0, CEIM_OFS_ENABLE, 32'h0);
        chk(rdat, 32'h000F_0000);
        event_pulse <= CEIM_EVT_MASK;
        @(posedge clk);
        event_pulse <= 32'h0;
        avs_byteenable <= 4'h4;
        access(1'b1, CEIM_OFS_STATUS, 32'hFFFF_FFFF);
        avs_byteenable <= 4'hF;
        access(1'b0, CEIM_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000_0F1F);
        access(1'b1, CEIM_OFS_STATUS, 32'hFFFF_FFFF);
        access(1'b0, CEIM_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000_0000);
        stop_test();
    end

    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule : test_camera_event_irq_mask
`default_nettype wire

// >>> verilog/ceim_irq_mask.sv
`timescale 1ns/1ns
`default_nettype none
module ceim_irq_mask (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] event_pulse,
    output logic             irq
);
    import ceim_pkg::*;

    logic [31:0] enable_q;
    logic [31:0] status_q;
    logic [31:0] readdata_q;
    typedef enum logic [0:0] {
        CEIM_BUS_IDLE = 1'b0,
        CEIM_BUS_ACK  = 1'b1
    } ceim_bus_state_t;

    ceim_bus_state_t bus_state_q;
    ceim_bus_state_t bus_state_d;
    logic        bus_ack;
    logic        sel_status;
    logic        sel_enable;
    logic [31:0] gated;

    // Named enable bits
    logic        frame_start_int_allow;
    logic        line_end_int_allow;
    logic        line_start_int_allow;
    logic        frame_end_int_allow;
    logic        preamble_code_error_int_allow;
    logic        frame_height_error_int_allow;
    logic        false_sync_code_int_allow;
    logic        shifted_sync_code_int_allow;
    logic        queue_nonempty_int_allow;
    logic        queue_full_int_allow;
    logic        queue_threshold_int_allow;
    logic        queue_overflow_int_allow;
    logic        queue_underflow_int_allow;
    logic [31:0] be_mask;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] status_d;

    // One wait cycle per access, then acknowledge
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    assign wr_fire         = avs_write & bus_ack;
    assign rd_fire         = avs_read & ~bus_ack;
    assign avs_readdata    = readdata_q;
    assign sel_status      = (avs_address == CEIM_OFS_STATUS);
    assign sel_enable      = (avs_address == CEIM_OFS_ENABLE);

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    assign be_mask = lane_mask(avs_byteenable);

    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            CEIM_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_d = CEIM_BUS_ACK;
                end
            end
            CEIM_BUS_ACK: begin
                bus_state_d = CEIM_BUS_IDLE;
            end
            default: begin
                bus_state_d = CEIM_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state_q <= CEIM_BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    assign bus_ack = (bus_state_q == CEIM_BUS_ACK);

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_q <= CEIM_RST_ENABLE;
        end else if (wr_fire && avs_address == CEIM_OFS_ENABLE) begin
            enable_q <= (enable_q & ~be_mask)
                      | (avs_writedata & be_mask & CEIM_EVT_MASK);
        end
    end

    always_comb begin
        status_d = status_q;
        if (wr_fire && avs_address == CEIM_OFS_STATUS) begin
            status_d = status_d & ~(avs_writedata & be_mask);
        end
        status_d = (status_d | event_pulse) & CEIM_EVT_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= CEIM_RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_q <= CEIM_RDATA_UNMAPPED;
        end else if (rd_fire) begin
            case (avs_address)
                CEIM_OFS_STATUS: readdata_q <= status_q;
                CEIM_OFS_ENABLE: readdata_q <= enable_q;
                default:         readdata_q <= CEIM_RDATA_UNMAPPED;
            endcase
        end
    end

    assign frame_start_int_allow         = enable_q[CEIM_BIT_FRAME_START];
    assign line_end_int_allow            = enable_q[CEIM_BIT_LINE_END];
    assign line_start_int_allow          = enable_q[CEIM_BIT_LINE_START];
    assign frame_end_int_allow           = enable_q[CEIM_BIT_FRAME_END];
    assign preamble_code_error_int_allow = enable_q[CEIM_BIT_PREAMBLE_ERR];
    assign frame_height_error_int_allow  = enable_q[CEIM_BIT_HEIGHT_ERR];
    assign false_sync_code_int_allow     = enable_q[CEIM_BIT_FALSE_SYNC];
    assign shifted_sync_code_int_allow   = enable_q[CEIM_BIT_SHIFTED_SYNC];
    assign queue_nonempty_int_allow      = enable_q[CEIM_BIT_QUEUE_NONEMPTY];
    assign queue_full_int_allow          = enable_q[CEIM_BIT_QUEUE_FULL];
    assign queue_threshold_int_allow     = enable_q[CEIM_BIT_QUEUE_THRESHOLD];
    assign queue_overflow_int_allow      = enable_q[CEIM_BIT_QUEUE_OVERFLOW];
    assign queue_underflow_int_allow     = enable_q[CEIM_BIT_QUEUE_UNDERFLOW];

    generate
        for (genvar b = 0; b < 32; b++) begin : g_gate
            if (CEIM_EVT_MASK[b]) begin : g_used
                assign gated[b] = status_q[b] & enable_q[b];

                a_bit_latch: assert property (@(posedge clk) disable iff (rst)
                    event_pulse[b] |=> status_q[b])
                    else $error("event bit not latched");

                a_bit_masked: assert property (@(posedge clk) disable iff (rst)
                    !enable_q[b] |-> !gated[b])
                    else $error("masked bit reached irq");
            end else begin : g_rsvd
                assign gated[b] = 1'b0;
            end
        end
    endgenerate

    assign irq = |gated;

    a_line_end_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_LINE_END] && line_end_int_allow)
        |-> irq)
        else $error("line end not gated");

    a_line_start_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_LINE_START] && line_start_int_allow)
        |-> irq)
        else $error("line start not gated");

    a_frame_end_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_FRAME_END] && frame_end_int_allow)
        |-> irq)
        else $error("frame end not gated");

    a_preamble_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_PREAMBLE_ERR] && preamble_code_error_int_allow)
        |-> irq)
        else $error("preamble error not gated");

    a_height_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_HEIGHT_ERR] && frame_height_error_int_allow)
        |-> irq)
        else $error("height error not gated");

    a_false_sync_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_FALSE_SYNC] && false_sync_code_int_allow)
        |-> irq)
        else $error("false sync not gated");

    a_shifted_sync_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_SHIFTED_SYNC] && shifted_sync_code_int_allow)
        |-> irq)
        else $error("shifted sync not gated");

    a_nonempty_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_QUEUE_NONEMPTY] && queue_nonempty_int_allow)
        |-> irq)
        else $error("queue nonempty not gated");

    a_full_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_QUEUE_FULL] && queue_full_int_allow)
        |-> irq)
        else $error("queue full not gated");

    a_threshold_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_QUEUE_THRESHOLD] && queue_threshold_int_allow)
        |-> irq)
        else $error("queue threshold not gated");

    a_overflow_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_QUEUE_OVERFLOW] && queue_overflow_int_allow)
        |-> irq)
        else $error("queue overflow not gated");

    a_underflow_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[CEIM_BIT_QUEUE_UNDERFLOW] && queue_underflow_int_allow)
        |-> irq)
        else $error("queue underflow not gated");

    a_wait_first: assert property (@(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && !bus_ack)
        |-> avs_waitrequest)
        else $error("first cycle not stalled");

    a_one_wait: assert property (@(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && avs_waitrequest)
        |=> !avs_waitrequest)
        else $error("wait longer than one cycle");

    a_read_enable: assert property (@(posedge clk) disable iff (rst)
        (rd_fire && sel_enable)
        |=> avs_readdata == $past(enable_q))
        else $error("enable read wrong");

    a_read_status: assert property (@(posedge clk) disable iff (rst)
        (rd_fire && sel_status)
        |=> avs_readdata == $past(status_q))
        else $error("status read wrong");

    a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
        (rd_fire && !sel_enable && !sel_status)
        |=> avs_readdata == CEIM_RDATA_UNMAPPED)
        else $error("unmapped read not zero");

    a_status_reset: assert property (@(posedge clk)
        $past(rst)
        |-> (status_q == CEIM_RST_STATUS) && !irq)
        else $error("status not clear after reset");

    a_lane_keep: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && sel_enable && !avs_byteenable[2])
        |=> enable_q[23:16] == $past(enable_q[23:16]))
        else $error("unselected lane changed");

    a_all_masked: assert property (@(posedge clk) disable iff (rst)
        (enable_q == 32'h0000_0000)
        |-> !irq)
        else $error("irq with all masked");

    a_enable_reset: assert property (@(posedge clk)
        $past(rst) |-> enable_q == 32'h0)
        else $error("enable not zero after reset");

    a_frame_start_gate: assert property (@(posedge clk) disable iff (rst)
        (status_q[19] && enable_q[19]) |-> irq)
        else $error("frame start not gated");

    a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
        ((status_q & enable_q) == 32'h0) |-> !irq)
        else $error("masked event raised irq");

    a_event_latches: assert property (@(posedge clk) disable iff (rst)
        event_pulse[0] |=> status_q[0])
        else $error("event not latched");

    a_w1c_clears: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && avs_address == 8'h18 && avs_writedata[16] && avs_byteenable[2]
         && !event_pulse[16]) |=> !status_q[16])
        else $error("write one did not clear");

    a_w0_keeps: assert property (@(posedge clk) disable iff (rst)
        (status_q[8] && !(wr_fire && avs_address == 8'h18 && avs_writedata[8]))
        |=> status_q[8])
        else $error("status lost without clear");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (enable_q & ~32'h000F_0F1F) == 32'h0)
        else $error("reserved enable bit set");

    a_enable_write: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && avs_address == 8'h1C && avs_byteenable == 4'hF)
        |=> enable_q == ($past(avs_writedata) & 32'h000F_0F1F))
        else $error("enable write lost");

    a_irq_follows: assert property (@(posedge clk) disable iff (rst)
        (status_q[3] && enable_q[3]) [*2] |-> irq)
        else $error("irq dropped while pending");

    c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(irq));
    c_masked_latch: cover property (@(posedge clk) disable iff (rst)
        status_q[9] && !enable_q[9]);
    c_clear_race: cover property (@(posedge clk) disable iff (rst)
        wr_fire && avs_address == 8'h18 && |(avs_writedata & event_pulse));
    c_lane_enable: cover property (@(posedge clk) disable iff (rst)
        wr_fire && sel_enable && avs_byteenable != 4'hF);
    c_lane_status: cover property (@(posedge clk) disable iff (rst)
        wr_fire && sel_status && avs_byteenable != 4'hF);
endmodule : ceim_irq_mask
`default_nettype wire

// >>> verilog/ceim_pkg.sv
package ceim_pkg;
    localparam logic [7:0]  CEIM_OFS_STATUS = 8'h18;
    localparam logic [7:0]  CEIM_OFS_ENABLE = 8'h1C;
    localparam logic [31:0] CEIM_RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] CEIM_RST_ENABLE = 32'h0000_0000;
    // Implemented event bits 19:16, 11:8, 4:0
    localparam logic [31:0] CEIM_EVT_MASK   = 32'h000F_0F1F;
    localparam int CEIM_BIT_FRAME_START     = 19;
    localparam int CEIM_BIT_LINE_END        = 18;
    localparam int CEIM_BIT_LINE_START      = 17;
    localparam int CEIM_BIT_FRAME_END       = 16;
    localparam int CEIM_BIT_PREAMBLE_ERR    = 11;
    localparam int CEIM_BIT_HEIGHT_ERR      = 10;
    localparam int CEIM_BIT_FALSE_SYNC      = 9;
    localparam int CEIM_BIT_SHIFTED_SYNC    = 8;
    localparam int CEIM_BIT_QUEUE_NONEMPTY  = 4;
    localparam int CEIM_BIT_QUEUE_FULL      = 3;
    localparam int CEIM_BIT_QUEUE_THRESHOLD = 2;
    localparam int CEIM_BIT_QUEUE_OVERFLOW  = 1;
    localparam int CEIM_BIT_QUEUE_UNDERFLOW = 0;
    localparam logic [31:0] CEIM_RDATA_UNMAPPED = 32'h0000_0000;
endpackage : ceim_pkg
